/* rtl/tmc4_consts.vh */
`ifndef TMC4_CONSTS_VH
`define TMC4_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define TMC4_OFF_CFG4 8'h7D
`define TMC4_OFF_CFG5 8'h7C
`define TMC4_OFF_LOCK 8'h40
`define TMC4_OFF_TEST1 8'h7E
`define TMC4_OFF_TEST2 8'h7F

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TMC4_RST_CFG4 8'h00
`define TMC4_RST_CFG5 8'h01
`define TMC4_RST_TEST 8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TMC4_ROLE_LSB 0
`define TMC4_ROLE_MSB 1
`define TMC4_KILL_BIT 2
`define TMC4_CEIL_BIT 3
`define TMC4_BYP_LSB 4
`define TMC4_BYP_MSB 7
`define TMC4_FMT_BIT 0
`define TMC4_LOCK_BIT 1

// ----------------------------------------------------------------
// Pin role codes and disabled-limit codes
// ----------------------------------------------------------------
`define TMC4_ROLE_TACH 2'h0
`define TMC4_ROLE_OVT 2'h1
`define TMC4_ROLE_ALERT 2'h2
`define TMC4_ROLE_GPIO 2'h3
`define TMC4_LIM_OFF_OFS64 8'h00
`define TMC4_LIM_OFF_TWOS 8'h80

`endif

/* rtl/tmc4_limit_check.v */
`timescale 1ns/1ps
`default_nettype none
`include "tmc4_consts.vh"

module tmc4_limit_check (
    input wire [7:0] limit,
    input wire signedFormat,
    output wire limitOff
);

    // ----------------------------------------------------------------
    // Lowest code of the active temperature format disables the limit
    // ----------------------------------------------------------------
    assign limitOff = signedFormat ?
        (limit == `TMC4_LIM_OFF_TWOS) :
        (limit == `TMC4_LIM_OFF_OFS64); // RL3 RL9

endmodule
`default_nettype wire

/* rtl/tmc4_config_regs.v */
`timescale 1ns/1ps
`default_nettype none
`include "tmc4_consts.vh"

// Notes on behaviour
// (RL1) Two-bit field picks shared pin role: tach, overtemp, alert, GPIO.
// (RL2) Bit 2 set kills the overtemp output on all channels.
// (RL3) Limit at lowest format code disables that channel's overtemp limit.
// (RL4) Bit 3 picks full speed or per-fan maximum duty on overtemp.
// (RL5) Bits 4 to 7 bypass attenuators of 2.5V, core, 5V, 12V channels.
// (RL6) Lock bit set makes this configuration register read-only.
// (RL7) Test registers 0x7E and 0x7F are read-only and read zero.
// (RL8) Software should not write the test registers.
// (RL9) Format bit selects twos complement or offset-64 temperatures.
// (RL10) Writes to the test registers are ignored.
module tmc4_config_regs (
    input wire mclk,
    input wire rst,
    input wire [7:0] regAddr,
    input wire [7:0] regWdata,
    input wire regWrite,
    input wire regRead,
    output reg [7:0] regRdata,
    input wire [23:0] overtempLimits,
    input wire [2:0] overtempRaw,
    input wire [23:0] fanMaxDuty,
    output reg [1:0] sharedPinRoleSelect,
    output reg fanFourTachSel,
    output reg overtempSignalSel,
    output reg alertSel,
    output reg gpioSel,
    output reg overtempOutput,
    output reg overtempFanCeilingSelect,
    output reg [23:0] fanOvertempDuty,
    output reg [3:0] bypassAtt,
    output reg signedTempFormat,
    output reg configLocked
);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    reg [7:0] cfgFour;
    reg [7:0] cfgFive;
    wire [2:0] limitOff;
    wire [7:0] next_cfgFour;
    reg [7:0] next_rdata;
    reg [2:0] chanTrip;
    integer i;

    function isAddr;
        input [7:0] a;
        input [7:0] b;
        begin
            isAddr = (a == b);
        end
    endfunction

    // ----------------------------------------------------------------
    // Per-channel limit disable detection
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : gChan
            tmc4_limit_check uCheck (
                .limit(overtempLimits[8*g+7:8*g]),
                .signedFormat(cfgFive[`TMC4_FMT_BIT]),
                .limitOff(limitOff[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    assign next_cfgFour = (regWrite && !configLocked &&
        isAddr(regAddr, `TMC4_OFF_CFG4)) ? regWdata : cfgFour; // RL6

    always @(posedge mclk) begin
        if (rst) begin
            cfgFour <= `TMC4_RST_CFG4;
            cfgFive <= `TMC4_RST_CFG5;
            configLocked <= 1'b0;
        end else begin
            cfgFour <= next_cfgFour;
            if (regWrite && !configLocked &&
                isAddr(regAddr, `TMC4_OFF_CFG5)) begin
                cfgFive <= regWdata; // RL9
            end
            if (regWrite && isAddr(regAddr, `TMC4_OFF_LOCK) &&
                regWdata[`TMC4_LOCK_BIT]) begin
                configLocked <= 1'b1; // RL6
            end
        end
    end

    // ----------------------------------------------------------------
    // Read mux; test registers always read zero
    // ----------------------------------------------------------------
    always @* begin
        next_rdata = 8'h00;
        if (isAddr(regAddr, `TMC4_OFF_CFG4)) begin
            next_rdata = cfgFour;
        end else if (isAddr(regAddr, `TMC4_OFF_CFG5)) begin
            next_rdata = cfgFive;
        end else if (isAddr(regAddr, `TMC4_OFF_LOCK)) begin
            next_rdata = {6'h00, configLocked, 1'b0};
        end else if (isAddr(regAddr, `TMC4_OFF_TEST1) ||
            isAddr(regAddr, `TMC4_OFF_TEST2)) begin
            next_rdata = `TMC4_RST_TEST; // RL7 RL10
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            regRdata <= 8'h00;
        end else if (regRead) begin
            regRdata <= next_rdata;
        end else begin
            regRdata <= 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // Overtemp qualification per channel
    // ----------------------------------------------------------------
    always @* begin
        for (i = 0; i < 3; i = i + 1) begin
            chanTrip[i] = overtempRaw[i] & ~limitOff[i]; // RL3
        end
    end

    // ----------------------------------------------------------------
    // Decoded outputs
    // ----------------------------------------------------------------
    always @(posedge mclk) begin
        if (rst) begin
            sharedPinRoleSelect <= `TMC4_ROLE_TACH;
            fanFourTachSel <= 1'b1;
            overtempSignalSel <= 1'b0;
            alertSel <= 1'b0;
            gpioSel <= 1'b0;
            overtempOutput <= 1'b0;
            overtempFanCeilingSelect <= 1'b0;
            fanOvertempDuty <= 24'hFFFFFF;
            bypassAtt <= 4'h0;
            signedTempFormat <= 1'b1;
        end else begin
            sharedPinRoleSelect <=
                next_cfgFour[`TMC4_ROLE_MSB:`TMC4_ROLE_LSB]; // RL1
            fanFourTachSel <= (next_cfgFour[1:0] == `TMC4_ROLE_TACH);
            overtempSignalSel <= (next_cfgFour[1:0] == `TMC4_ROLE_OVT);
            alertSel <= (next_cfgFour[1:0] == `TMC4_ROLE_ALERT);
            gpioSel <= (next_cfgFour[1:0] == `TMC4_ROLE_GPIO);
            overtempOutput <= ~next_cfgFour[`TMC4_KILL_BIT] &
                (|chanTrip); // RL2
            overtempFanCeilingSelect <= next_cfgFour[`TMC4_CEIL_BIT];
            fanOvertempDuty <= next_cfgFour[`TMC4_CEIL_BIT] ?
                fanMaxDuty : 24'hFFFFFF; // RL4
            bypassAtt <=
                next_cfgFour[`TMC4_BYP_MSB:`TMC4_BYP_LSB]; // RL5
            signedTempFormat <= cfgFive[`TMC4_FMT_BIT]; // RL9
        end
    end

endmodule
`default_nettype wire

/* sim/tmc4_config_regs_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module tmc4_config_regs_sva (
    input wire mclk,
    input wire rst,
    input wire [7:0] regAddr,
    input wire [7:0] regWdata,
    input wire regWrite,
    input wire regRead,
    input wire [7:0] regRdata,
    input wire [1:0] sharedPinRoleSelect,
    input wire overtempSignalSel,
    input wire overtempFanCeilingSelect,
    input wire [23:0] fanOvertempDuty,
    input wire [3:0] bypassAtt,
    input wire configLocked
);
    wire wr4 = regWrite && regAddr == 8'h7D && !configLocked;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);
    chk_role_write: assert property (
        wr4 |=> sharedPinRoleSelect == $past(regWdata[1:0]))
        else $error("role not taken");
    chk_role_decode: assert property (
        overtempSignalSel == (sharedPinRoleSelect == 2'h1))
        else $error("role decode wrong");
    chk_ceil_write: assert property (
        wr4 |=> overtempFanCeilingSelect == $past(regWdata[3]))
        else $error("ceiling not taken");
    chk_full_speed: assert property (
        !overtempFanCeilingSelect |-> fanOvertempDuty == 24'hFFFFFF)
        else $error("fans not full");
    chk_bypass_write: assert property (
        wr4 |=> bypassAtt == $past(regWdata[7:4]))
        else $error("bypass not taken");
    chk_lock_freeze: assert property (
        configLocked && regWrite |=> $stable(bypassAtt))
        else $error("locked write took");
    chk_lock_sticky: assert property (
        configLocked |=> configLocked)
        else $error("lock dropped");
    chk_test_zero: assert property (
        regRead && regAddr[7:1] == 7'h3F |=> regRdata == 8'h00)
        else $error("test reg not zero");
    cover property (wr4);
    cover property (configLocked && regWrite);
    cover property (regRead && regAddr == 8'h7E);
endmodule
bind tmc4_config_regs tmc4_config_regs_sva i_chk (.*);
`default_nettype wire

/* sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic mclk = 1'h0, rst = 1'h1, regWrite = 1'h0, regRead = 1'h0;
    logic [7:0] regAddr = 8'h00, regWdata = 8'h00, d, lim;
    logic [2:0] overtempRaw = 3'h0;
    logic [23:0] overtempLimits = 24'h0, fanMaxDuty = 24'h0;
    logic [31:0] seed = 32'h296F, r;
    int nMismatch = 0, checkCount = 0;
    logic [7:0] mCfg4 = 8'h00, mCfg5 = 8'h01;
    logic mLock = 1'h0;
    wire [7:0] regRdata;
    wire [1:0] sharedPinRoleSelect;
    wire [3:0] bypassAtt;
    wire [23:0] fanOvertempDuty;
    wire fanFourTachSel, overtempSignalSel, alertSel, gpioSel;
    wire overtempOutput, overtempFanCeilingSelect;
    wire signedTempFormat, configLocked;
    wire [3:0] sel = {gpioSel, alertSel, overtempSignalSel, fanFourTachSel};
    tmc4_config_regs i_dut (.*);
    always #5 mclk = ~mclk;
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function logic [7:0] mRead(input logic [7:0] a);
        if (a == 8'h7D) return mCfg4;
        if (a == 8'h7C) return mCfg5;
        if (a == 8'h40) return {6'h00, mLock, 1'h0};
        return 8'h00;
    endfunction
    task ck(input logic [23:0] g, input logic [23:0] e);
        checkCount++;
        if (g !== e) begin
            nMismatch++;
            $display("wrong value at %0t: %h %h", $time, g, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= v;
        regWrite <= 1'h1;
        if (a == 8'h7D && !mLock) mCfg4 = v;
        if (a == 8'h7C && !mLock) mCfg5 = v;
        if (a == 8'h40 && v[1]) mLock = 1'h1;
        @(posedge mclk);
        regWrite <= 1'h0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        regAddr <= a;
        regRead <= 1'h1;
        @(posedge mclk);
        regRead <= 1'h0;
        @(negedge mclk);
        ck(regRdata, e);
        ck(regRdata, mRead(a));
    endtask
    task conclude;
        $display("mismatches %0d checks %0d", nMismatch, checkCount);
        if (nMismatch == 0 && checkCount > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #100000;
        nMismatch++;
        conclude;
    end
    initial begin
        r = xs();
        fanMaxDuty <= r[23:0];
        repeat (2) @(posedge mclk);
        rst <= 1'h0;
        rd(8'h7D, 8'h00);
        rd(8'h7C, 8'h01);
        for (int i = 0; i < 8; i++) begin
            r = xs();
            d = {r[7:2], i[1:0]};
            wr(8'h7D, d);
            @(negedge mclk);
            ck(sel, 4'h1 << i[1:0]);
            ck(bypassAtt, d[7:4]);
            ck(sharedPinRoleSelect, d[1:0]);
            ck(overtempFanCeilingSelect, d[3]);
            ck(fanOvertempDuty, d[3] ? fanMaxDuty : 24'hFFFFFF);
            rd(8'h7D, d);
        end
        for (int i = 0; i < 8; i++) begin
            lim = i[2] ? {i[1], 7'h00} : 8'h41;
            wr(8'h7C, {7'h00, i[1]});
            wr(8'h7D, {5'h00, i[0], 2'h0});
            overtempLimits <= {3{lim}};
            overtempRaw <= 3'h7;
            repeat (3) @(negedge mclk);
            ck(overtempOutput, !i[0] && !i[2]);
            ck(signedTempFormat, i[1]);
        end
        wr(8'h7E, 8'hFF);
        wr(8'h7F, 8'hA5);
        rd(8'h7E, 8'h00);
        rd(8'h7F, 8'h00);
        rd(8'h10, 8'h00);
        ck(configLocked, 1'h0);
        wr(8'h7D, 8'h5A);
        wr(8'h40, 8'h02);
        @(negedge mclk);
        ck(configLocked, 1'h1);
        wr(8'h7D, 8'hA5);
        wr(8'h7C, 8'h00);
        @(negedge mclk);
        ck(bypassAtt, 4'h5);
        ck(signedTempFormat, 1'h1);
        rd(8'h40, 8'h02);
        rd(8'h7D, 8'h5A);
        rd(8'h7C, 8'h01);
        conclude;
    end
endmodule
`default_nettype wire
